/* inc/ddslp_regs.vh */
/*
  constants of the display driver serial load port: widths, depths and
  reset values. assumes inclusion by bare name from src/ design files.
*/
`ifndef DDSLP_REGS_VH
`define DDSLP_REGS_VH

`define DDSLP_WORD_W      16
`define DDSLP_FIFO_DEPTH  4
`define DDSLP_FIFO_AW     2
`define DDSLP_LINES       8
`define DDSLP_SHIFT_RST   16'h0000
`define DDSLP_WORD_RST    16'h0000
`define DDSLP_BIT_RST     1'b0
`define DDSLP_SEL_RST     1'b1

`endif

/* src/ddslp_fifo.v */
/*
  small synchronous fifo with valid/ready on both sides.
  assumes one clock, asynchronous active-high reset.
*/
`default_nettype none

module ddslp_fifo #(
  parameter W     = 16,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire         clk_i,       // system clock
  input  wire         reset_i,     // async reset, active high
  input  wire         in_valid_i,  // write request
  output wire         in_ready_o,  // space available
  input  wire [W-1:0] in_data_i,   // write data
  output wire         out_valid_o, // data available
  input  wire         out_ready_i, // consumer takes data
  output wire [W-1:0] out_data_o   // head word
);

  reg [W-1:0]  mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0]   count_r;
  wire         push;
  wire         pop;
  localparam integer  DEPTH_I = DEPTH;
  localparam integer  LAST_I  = DEPTH - 1;
  localparam [AW:0]   DEPTH_C = DEPTH_I[AW:0];
  localparam [AW-1:0] LAST_C  = LAST_I[AW-1:0];

  assign in_ready_o  = (count_r != DEPTH_C);
  assign out_valid_o = (count_r != {(AW+1){1'b0}});
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_i)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data_i;
  end

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == LAST_C) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == LAST_C) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      if (push & ~pop)
        count_r <= count_r + 1'b1;
      else if (pop & ~push)
        count_r <= count_r - 1'b1;
    end
  end

endmodule // ddslp_fifo

`default_nettype wire

/* src/ddslp_top.v */
/*
  serial load port of an eight-digit led display driver: 16-bit shift
  register on the host's serial clock, word capture on the load/select
  strobe, daisy-chain output, and off-state handling of the display lines.
  assumes the serial pins are asynchronous to clk_i and that the command
  decoder outside consumes words through word_valid_o/word_ready_i and
  supplies the on/off state of each digit and segment line.
*/
`default_nettype none
`include "ddslp_regs.vh"

module ddslp_top #(
  parameter SELECT_GATES = 1, // 1: clock only counts while select low
  parameter OFF_RELEASE  = 1, // 1: off lines released, 0: driven
  parameter WORD_W       = `DDSLP_WORD_W,
  parameter FIFO_DEPTH   = `DDSLP_FIFO_DEPTH,
  parameter FIFO_AW      = `DDSLP_FIFO_AW,
  parameter LINES        = `DDSLP_LINES
) (
  input  wire              clk_i,                      // 100 mhz clock
  input  wire              reset_i,                    // async reset
  input  wire              sclk_i,                     // host serial clock
  input  wire              din_i,                      // serial data in
  input  wire              load_select_n_i,            // load / select
  output reg               dout_o,                     // serial data out
  output reg  [WORD_W-1:0] word_o,                     // captured word
  output reg               word_valid_o,               // word pending
  input  wire              word_ready_i,               // decoder takes
  output reg               overrun_o,                  // word dropped
  output reg               fifo_full_o,                // no space left
  output reg               programmed_o,               // word seen
  input  wire [LINES-1:0]  digit_on_i,                 // digit states
  input  wire [LINES-1:0]  seg_on_i,                   // segment states
  output reg  [LINES-1:0]  digit_drive_lines_o,        // digit level
  output reg  [LINES-1:0]  digit_drive_lines_oe_n_o,   // low: driven
  output reg  [LINES-1:0]  segment_drive_lines_o,      // segment level
  output reg  [LINES-1:0]  segment_drive_lines_oe_n_o  // low: driven
);

  localparam [LINES-1:0] ZERO_L = {LINES{1'b0}};
  localparam [LINES-1:0] ONES_L = {LINES{1'b1}};
  localparam [LINES-1:0] DIG_OFF_LVL = (OFF_RELEASE != 0) ? ZERO_L : ONES_L;
  localparam [LINES-1:0] OFF_OE_N    = (OFF_RELEASE != 0) ? ONES_L : ZERO_L;

  // two-stage synchronisers
  // equal depth on sclk and din keeps each bit with its edge
  reg              sclk_s1_r;
  reg              sclk_s2_r;
  reg              sclk_d_r;
  reg              din_s1_r;
  reg              din_s2_r;
  reg              sel_s1_r;
  reg              sel_s2_r;
  reg              sel_d_r;

  reg [WORD_W-1:0] shift_r;
  reg              leave_r;
  reg [WORD_W-1:0] shift_nxt;
  reg              leave_nxt;
  reg              dout_nxt;
  wire             clk_active;
  wire             sclk_rise;
  wire             sclk_fall;
  wire             load_rise;

  wire             fifo_in_ready;
  wire             fifo_out_valid;
  wire [WORD_W-1:0] fifo_out_data;
  wire             fifo_pop;
  wire             programmed_nxt;
  wire [LINES-1:0] dig_on;
  wire [LINES-1:0] seg_on;

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sclk_s1_r <= `DDSLP_BIT_RST;
      sclk_s2_r <= `DDSLP_BIT_RST;
      sclk_d_r  <= `DDSLP_BIT_RST;
      din_s1_r  <= `DDSLP_BIT_RST;
      din_s2_r  <= `DDSLP_BIT_RST;
      sel_s1_r  <= `DDSLP_SEL_RST;
      sel_s2_r  <= `DDSLP_SEL_RST;
      sel_d_r   <= `DDSLP_SEL_RST;
    end
    else
    begin
      sclk_s1_r <= sclk_i;
      sclk_s2_r <= sclk_s1_r;
      sclk_d_r  <= sclk_s2_r;
      din_s1_r  <= din_i;
      din_s2_r  <= din_s1_r;
      sel_s1_r  <= load_select_n_i;
      sel_s2_r  <= sel_s1_r;
      sel_d_r   <= sel_s2_r;
    end
  end

  // select-gated serial clock
  assign clk_active = (SELECT_GATES == 0) | ~sel_s2_r;
  assign sclk_rise  = sclk_s2_r & ~sclk_d_r & clk_active;
  assign sclk_fall  = ~sclk_s2_r & sclk_d_r & clk_active;
  assign load_rise  = sel_s2_r & ~sel_d_r;

  // shift path and daisy-chain output
  always @*
  begin
    shift_nxt = shift_r;
    leave_nxt = leave_r;
    dout_nxt  = dout_o;
    if (sclk_rise)
    begin
      shift_nxt = {shift_r[WORD_W-2:0], din_s2_r};
      leave_nxt = shift_r[WORD_W-1];
    end
    if (sclk_fall)
      dout_nxt = leave_r;
  end

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      shift_r <= `DDSLP_SHIFT_RST;
      leave_r <= `DDSLP_BIT_RST;
      dout_o  <= `DDSLP_BIT_RST;
    end
    else
    begin
      shift_r <= shift_nxt;
      leave_r <= leave_nxt;
      dout_o  <= dout_nxt;
    end
  end

  // captured words queue toward the decoder
  ddslp_fifo #(
    .W     (WORD_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (load_rise),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (shift_r),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  // output stage refills when empty or being taken
  assign fifo_pop = fifo_out_valid & (~word_valid_o | word_ready_i);

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      word_o       <= `DDSLP_WORD_RST;
      word_valid_o <= `DDSLP_BIT_RST;
      overrun_o    <= `DDSLP_BIT_RST;
      fifo_full_o  <= `DDSLP_BIT_RST;
    end
    else
    begin
      if (fifo_pop)
      begin
        word_o       <= fifo_out_data;
        word_valid_o <= 1'b1;
      end
      else if (word_ready_i)
        word_valid_o <= 1'b0;
      // a strobe into a full fifo is dropped and flagged
      overrun_o   <= load_rise & ~fifo_in_ready;
      fifo_full_o <= ~fifo_in_ready;
    end
  end

  // blank until the first word has been captured
  assign programmed_nxt = programmed_o | load_rise;
  assign dig_on = digit_on_i & {LINES{programmed_o}};
  assign seg_on = seg_on_i & {LINES{programmed_o}};

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      programmed_o               <= `DDSLP_BIT_RST;
      digit_drive_lines_o        <= DIG_OFF_LVL;
      digit_drive_lines_oe_n_o   <= OFF_OE_N;
      segment_drive_lines_o      <= ZERO_L;
      segment_drive_lines_oe_n_o <= OFF_OE_N;
    end
    else
    begin
      programmed_o <= programmed_nxt;
      // digit on sinks current: driven low
      digit_drive_lines_o      <= ~dig_on & DIG_OFF_LVL;
      digit_drive_lines_oe_n_o <= ~dig_on & OFF_OE_N;
      // segment on sources current: driven high
      segment_drive_lines_o      <= seg_on;
      segment_drive_lines_oe_n_o <= ~seg_on & OFF_OE_N;
    end
  end

endmodule // ddslp_top

`default_nettype wire

/* verif/ddslp_asserts.sv */
/*
  assertion checker of the serial load port, bound to ddslp_top.
  assumes default parameters and serial clock levels of 4 clk or more.
*/
`default_nettype none
module ddslp_asserts (
  input wire logic        clk_i, reset_i, sclk_i, load_select_n_i, dout_o,
  input wire logic        word_valid_o, word_ready_i, overrun_o,
  input wire logic        fifo_full_o, programmed_o,
  input wire logic [15:0] word_o,
  input wire logic [7:0]  digit_on_i, seg_on_i, digit_drive_lines_o,
  input wire logic [7:0]  digit_drive_lines_oe_n_o, segment_drive_lines_o,
  input wire logic [7:0]  segment_drive_lines_oe_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_load; $rose(load_select_n_i) && !word_valid_o; endsequence
  sequence s_word; ##[3:6] word_valid_o; endsequence
  a_dout_edge:
    assert property ($changed(dout_o) |-> !sclk_i && !$past(sclk_i, 2))
    else $error("dout moved off a falling clock");
  a_select_gate:
    assert property (load_select_n_i [*6] |-> $stable(dout_o))
    else $error("dout moved while deselected");
  a_load_word:
    assert property (s_load |-> s_word)
    else $error("strobe did not capture a word");
  a_prog_sticky:
    assert property (programmed_o |=> programmed_o)
    else $error("programmed flag dropped");
  a_blank_start:
    assert property (!programmed_o |-> &digit_drive_lines_oe_n_o
      && &segment_drive_lines_oe_n_o) else $error("display lit early");
  a_digit_follow:
    assert property ($past(programmed_o) |-> digit_drive_lines_o == 8'h00
      && digit_drive_lines_oe_n_o == ~$past(digit_on_i))
    else $error("digit lines wrong");
  a_seg_follow:
    assert property ($past(programmed_o) |-> segment_drive_lines_o ==
      $past(seg_on_i) && segment_drive_lines_oe_n_o == ~$past(seg_on_i))
    else $error("segment lines wrong");
  a_word_hold:
    assert property (word_valid_o && !word_ready_i |=> word_valid_o
      && $stable(word_o)) else $error("word changed before taken");
  a_overrun_full:
    assert property (overrun_o |-> $past(fifo_full_o))
    else $error("overrun without full fifo");
endmodule // ddslp_asserts
`default_nettype wire

/* verif/ddslp_host.sv */
/*
  host serial master model: shifts words msb first at 6.25 mhz.
  assumes calls from the bench, one transfer at a time.
*/
`default_nettype none
module ddslp_host (
  input  wire logic   dout_i,  // chained output of the port
  output logic        sclk_o,  // serial clock, idle low
  output logic        din_o,   // serial data
  output logic        sel_n_o, // load / select
  output logic [15:0] seen_o   // dout bits after each fall
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sclk_o = 1'b0;
    din_o = 1'b0;
    sel_n_o = 1'b1;
    seen_o = 16'h0000;
  end
  // sel high keeps select low for the whole transfer
  task automatic send(input logic [15:0] w, input bit sel);
    sel_n_o <= ~sel;
    #80;
    for (int i = 15; i >= 0; i--)
    begin
      din_o <= w[i];
      #40 sclk_o <= 1'b1;
      #80 sclk_o <= 1'b0;
      #40 seen_o <= {seen_o[14:0], dout_i};
    end
    din_o <= ~w[0];
    sel_n_o <= 1'b1;
    #160;
  endtask
endmodule // ddslp_host
`default_nettype wire

/* verif/ddslp_top_test.sv */
/*
  self-checking bench of ddslp_top driven by the host model.
  assumes default design parameters.
*/
`default_nettype none
module ddslp_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, reset_i, word_ready_i;
  logic ovr = 1'b0;
  logic [7:0] digit_on_i, seg_on_i;
  wire logic sclk_i, din_i, load_select_n_i, dout_o, word_valid_o;
  wire logic overrun_o, fifo_full_o, programmed_o;
  wire logic [15:0] word_o, seen;
  wire logic [7:0] digit_drive_lines_o, digit_drive_lines_oe_n_o;
  wire logic [7:0] segment_drive_lines_o, segment_drive_lines_oe_n_o;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  ddslp_top dut (
    .clk_i                      (clk_i),
    .reset_i                    (reset_i),
    .sclk_i                     (sclk_i),
    .din_i                      (din_i),
    .load_select_n_i            (load_select_n_i),
    .dout_o                     (dout_o),
    .word_o                     (word_o),
    .word_valid_o               (word_valid_o),
    .word_ready_i               (word_ready_i),
    .overrun_o                  (overrun_o),
    .fifo_full_o                (fifo_full_o),
    .programmed_o               (programmed_o),
    .digit_on_i                 (digit_on_i),
    .seg_on_i                   (seg_on_i),
    .digit_drive_lines_o        (digit_drive_lines_o),
    .digit_drive_lines_oe_n_o   (digit_drive_lines_oe_n_o),
    .segment_drive_lines_o      (segment_drive_lines_o),
    .segment_drive_lines_oe_n_o (segment_drive_lines_oe_n_o)
  );
  ddslp_host host (.dout_i(dout_o), .sclk_o(sclk_i), .din_o(din_i),
    .sel_n_o(load_select_n_i), .seen_o(seen));
  task chk(input logic [15:0] s, e, input string nm);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  task end_sim;
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task pop(input logic [15:0] e);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      #1 n++;
    end while (word_valid_o !== 1'b1 && n < 400);
    chk(word_o, e, "word");
    @(posedge clk_i) word_ready_i <= 1'b1;
    @(posedge clk_i) word_ready_i <= 1'b0;
  endtask
  task t_blank;
    @(posedge clk_i) digit_on_i <= 8'hff;
    seg_on_i <= 8'hff;
    repeat (3) @(posedge clk_i);
    #1 chk(digit_drive_lines_oe_n_o, 8'hff, "blank dig");
    chk(segment_drive_lines_oe_n_o, 8'hff, "blank seg");
    chk(segment_drive_lines_o, 8'h00, "blank seg lvl");
    chk(programmed_o, 1'b0, "unprogrammed");
  endtask
  task t_chain;
    host.send(16'ha53c, 1);
    pop(16'ha53c);
    chk(programmed_o, 1'b1, "programmed");
    host.send(16'h0ff1, 1);
    chk(seen, 16'ha53c, "chain");
    pop(16'h0ff1);
  endtask
  task t_gate;
    host.send(16'h7e81, 0);
    host.send(16'h3c96, 1);
    chk(seen, 16'h0ff1, "gated");
    pop(16'h3c96);
  endtask
  task t_full;
    for (int k = 0; k < 5; k++)
      host.send(16'hc000 + 16'(k), 1);
    #1 chk(fifo_full_o, 1'b1, "full");
    chk(ovr, 1'b0, "no overrun");
    host.send(16'hdead, 1);
    chk(ovr, 1'b1, "overrun");
    for (int k = 0; k < 5; k++)
      pop(16'hc000 + 16'(k));
    repeat (3) @(posedge clk_i);
    #1 chk(word_valid_o, 1'b0, "drained");
  endtask
  task t_display;
    @(posedge clk_i) digit_on_i <= 8'ha5;
    seg_on_i <= 8'h3c;
    repeat (3) @(posedge clk_i);
    #1 chk(digit_drive_lines_oe_n_o, 8'h5a, "digit oe");
    chk(digit_drive_lines_o, 8'h00, "digit level");
    chk(segment_drive_lines_o, 8'h3c, "seg level");
    chk(segment_drive_lines_oe_n_o, 8'hc3, "seg oe");
  endtask
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (overrun_o === 1'b1)
      ovr <= 1'b1;
    if (cyc == 8000)
    begin
      error_cnt++;
      end_sim;
    end
  end
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    reset_i = 1'b1;
    word_ready_i = 1'b0;
    digit_on_i = 8'h00;
    seg_on_i = 8'h00;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    t_blank;
    t_chain;
    t_gate;
    t_full;
    t_display;
    end_sim;
  end
endmodule // ddslp_top_test
bind ddslp_top ddslp_asserts chk_u (
  .clk_i                      (clk_i),
  .reset_i                    (reset_i),
  .sclk_i                     (sclk_i),
  .load_select_n_i            (load_select_n_i),
  .dout_o                     (dout_o),
  .word_valid_o               (word_valid_o),
  .word_ready_i               (word_ready_i),
  .overrun_o                  (overrun_o),
  .fifo_full_o                (fifo_full_o),
  .programmed_o               (programmed_o),
  .word_o                     (word_o),
  .digit_on_i                 (digit_on_i),
  .seg_on_i                   (seg_on_i),
  .digit_drive_lines_o        (digit_drive_lines_o),
  .digit_drive_lines_oe_n_o   (digit_drive_lines_oe_n_o),
  .segment_drive_lines_o      (segment_drive_lines_o),
  .segment_drive_lines_oe_n_o (segment_drive_lines_oe_n_o)
);
`default_nettype wire
